// file: core/ucs_pkg.sv
// constants and types shared by the line and modem status block
package ucs_pkg;
	// register offsets on the three-bit address
	localparam logic [2:0] OFS_RX_BUFFER     = 3'h0;
	localparam logic [2:0] OFS_IRQ_ENABLE    = 3'h1;
	localparam logic [2:0] OFS_IRQ_IDENT     = 3'h2;
	localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] OFS_LINE_STATUS   = 3'h5;
	localparam logic [2:0] OFS_MODEM_STATUS  = 3'h6;

	// line status field positions
	localparam int LS_DATA_READY = 0;
	localparam int LS_OVERRUN    = 1;
	localparam int LS_PARITY     = 2;
	localparam int LS_FRAMING    = 3;
	localparam int LS_BREAK      = 4;
	localparam int LS_HOLD_EMPTY = 5;
	localparam int LS_ALL_EMPTY  = 6;

	// modem control field positions
	localparam int MC_TERM_READY = 0;
	localparam int MC_REQ_SEND   = 1;
	localparam int MC_USER_A     = 2;
	localparam int MC_USER_B     = 3;
	localparam int MC_LOOP       = 4;

	// interrupt enable field positions
	localparam int IE_RX_DATA = 0;
	localparam int IE_TX_HOLD = 1;
	localparam int IE_RX_LINE = 2;
	localparam int IE_MODEM   = 3;

	// reset values
	localparam logic [4:0] MODEM_CONTROL_RST = 5'h00;
	localparam logic [3:0] IRQ_ENABLE_RST    = 4'h0;
	localparam logic [4:0] LINE_FLAGS_RST    = 5'h00;
	localparam logic [3:0] MODEM_DELTA_RST   = 4'h0;
	localparam logic       TX_HOLD_EMPTY_RST = 1'b1;

	// identification codes, highest priority first
	localparam logic [3:0] IRQ_ID_RX_LINE = 4'h6;
	localparam logic [3:0] IRQ_ID_RX_DATA = 4'h4;
	localparam logic [3:0] IRQ_ID_TX_HOLD = 4'h2;
	localparam logic [3:0] IRQ_ID_MODEM   = 4'h0;
	localparam logic [3:0] IRQ_ID_NONE    = 4'h1;

	// modem status, in register order from bit 7 downward
	typedef struct packed {
		logic carrier;
		logic ring;
		logic set_ready;
		logic clear_send;
	} ucs_modem_t;
endpackage

// file: core/ucs_sticky.sv
// sticky flags with set deferred while a status read is in progress
`timescale 1ns/100ps
module ucs_sticky #(
	parameter int           W   = 4,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	input  wire logic         hold_i,
	output logic      [W-1:0] flag_o,
	output logic      [W-1:0] pend_o
);
	logic [W-1:0] flag_q, flag_d;
	logic [W-1:0] pend_q, pend_d;

	always_comb begin
		if (hold_i) begin
			// a read is open: remember events, show them after it ends
			pend_d = pend_q | set_i;
			flag_d = flag_q;
		end else begin
			pend_d = '0;
			// set beats clear so a same-cycle event is not lost
			flag_d = (flag_q & ~clr_i) | set_i | pend_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= RST;
			pend_q <= '0;
		end else begin
			flag_q <= flag_d;
			pend_q <= pend_d;
		end
	end

	assign flag_o = flag_q;
	assign pend_o = pend_q;
endmodule // ucs_sticky

// file: core/ucs_line_modem.sv
// line status, modem control, modem status and interrupt identification
// Functional notes
// - data ready sets on receive-buffer load, clears on receive-buffer read
// - overrun sets when a load finds data ready still set; line status read clears
// - parity error sets on a bad-parity character; line status read clears
// - framing error sets on a zero stop bit; line status read clears
// - break flag sets on a break character; line status read clears
// - any receive error raises the top-priority interrupt when its enable is set
// - holding empty sets on move to shifter, clears on holding write only
// - enabled holding empty gives priority three; identification read clears it
// - transmitter empty only while holding and shifter both empty
// - line status bit seven always reads zero
// - modem control read/write; low four bits drive active-low pins
// - modem control upper three bits always read zero
// - loopback holds serial output at mark, feeds shifter output to receiver
// - loopback ignores modem inputs, routes controls inward, forces pins high
// - loopback modem interrupts come from control bits, still enable-gated
// - deltas set on input change, all clear on modem status read
// - upper modem status bits are the inverse of the active-low pins
// - enabled modem change raises the lowest, priority-four interrupt
// - loopback maps send request, terminal ready, user a, user b to status
// - ring delta sets only on ring pin going low to high
// - receiver flags and modem deltas set during their own status read wait until the strobe ends
// - receive error flags persist across clean characters until status read
`timescale 1ns/100ps
module ucs_line_modem (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] addr_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       dlab_i,
	output logic      [7:0] rdata_o,
	input  wire logic [7:0] rx_data_i,
	input  wire logic       rx_char_done_i,
	input  wire logic       rx_parity_bad_i,
	input  wire logic       rx_stop_bad_i,
	input  wire logic       rx_break_i,
	input  wire logic       tx_hold_to_shift_i,
	input  wire logic       tx_shift_idle_i,
	input  wire logic       tx_shift_out_i,
	output logic            tx_hold_load_o,
	input  wire logic       serial_rx_pin_i,
	output logic            serial_tx_pin_o,
	output logic            rx_serial_o,
	input  wire logic       clear_send_n_i,
	input  wire logic       set_ready_n_i,
	input  wire logic       ring_n_i,
	input  wire logic       carrier_n_i,
	output logic            term_ready_n_o,
	output logic            req_send_n_o,
	output logic            user_output_a_n_o,
	output logic            user_output_b_n_o,
	output logic            irq_out_o
);
	logic [4:0]          modem_control_q, modem_control_d;
	logic [3:0]          irq_enable_reg_q, irq_enable_reg_d;
	logic                tx_hold_empty_q, tx_hold_empty_d;
	logic                tx_hold_empty_irq_q, tx_hold_empty_irq_d;
	ucs_pkg::ucs_modem_t stat_q, stat_d, stat_now;
	logic [7:0]          rdata_q, rdata_d;
	logic                rd_q, rd_d;
	logic                rb_rd_q, rb_rd_d;
	logic [2:0]          raddr_q, raddr_d;
	logic [4:0]          line_flags, line_pend, line_set, line_clr;
	logic [3:0]          delta, delta_pend, delta_set;
	logic                loop, ls_hold, ms_hold, ls_end, ms_end, rb_end, ii_end;
	logic                thr_wr, ier_wr, mcr_wr, rx_line_irq, tx_all_empty;
	logic [3:0]          irq_ident_reg;

	assign loop   = modem_control_q[ucs_pkg::MC_LOOP];
	assign thr_wr = wr_i && !dlab_i && addr_i == ucs_pkg::OFS_RX_BUFFER;
	assign ier_wr = wr_i && !dlab_i && addr_i == ucs_pkg::OFS_IRQ_ENABLE;
	assign mcr_wr = wr_i && addr_i == ucs_pkg::OFS_MODEM_CONTROL;
	assign ls_hold = rd_i && addr_i == ucs_pkg::OFS_LINE_STATUS;
	assign ms_hold = rd_i && addr_i == ucs_pkg::OFS_MODEM_STATUS;
	// clearing effects of a read act on its trailing edge
	assign ls_end = rd_q && !rd_i && raddr_q == ucs_pkg::OFS_LINE_STATUS;
	assign ms_end = rd_q && !rd_i && raddr_q == ucs_pkg::OFS_MODEM_STATUS;
	// dlab is taken with the strobe, so dropping it at the trailing edge cannot clear data ready
	assign rb_end = rb_rd_q && !rd_i;
	assign ii_end = rd_q && !rd_i && raddr_q == ucs_pkg::OFS_IRQ_IDENT;
	assign tx_hold_load_o = thr_wr;

	// receiver flags: errors only ever set by hardware, cleared by status read
	always_comb begin
		line_set = '0;
		line_set[ucs_pkg::LS_DATA_READY] = rx_char_done_i;
		line_set[ucs_pkg::LS_OVERRUN] = rx_char_done_i
			&& line_flags[ucs_pkg::LS_DATA_READY];
		line_set[ucs_pkg::LS_PARITY]  = rx_char_done_i && rx_parity_bad_i;
		line_set[ucs_pkg::LS_FRAMING] = rx_char_done_i && rx_stop_bad_i;
		line_set[ucs_pkg::LS_BREAK]   = rx_char_done_i && rx_break_i;
		line_clr = {{4{ls_end}}, 1'b0};
		line_clr[ucs_pkg::LS_DATA_READY] = rb_end;
	end

	ucs_sticky #(.W(5), .RST(ucs_pkg::LINE_FLAGS_RST)) u_line (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (line_set),
		.clr_i  (line_clr),
		.hold_i (ls_hold),
		.flag_o (line_flags),
		.pend_o (line_pend)
	);

	// modem inputs, replaced by the control bits in loopback
	always_comb begin
		if (loop) begin
			stat_now.clear_send = modem_control_q[ucs_pkg::MC_REQ_SEND];
			stat_now.set_ready  = modem_control_q[ucs_pkg::MC_TERM_READY];
			stat_now.ring       = modem_control_q[ucs_pkg::MC_USER_A];
			stat_now.carrier    = modem_control_q[ucs_pkg::MC_USER_B];
		end else begin
			stat_now.clear_send = !clear_send_n_i;
			stat_now.set_ready  = !set_ready_n_i;
			stat_now.ring       = !ring_n_i;
			stat_now.carrier    = !carrier_n_i;
		end
		stat_d = stat_now;
		delta_set[0] = stat_q.clear_send ^ stat_now.clear_send;
		delta_set[1] = stat_q.set_ready ^ stat_now.set_ready;
		// ring pin low to high is the status bit falling
		delta_set[2] = stat_q.ring && !stat_now.ring;
		delta_set[3] = stat_q.carrier ^ stat_now.carrier;
	end

	ucs_sticky #(.W(4), .RST(ucs_pkg::MODEM_DELTA_RST)) u_delta (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.set_i  (delta_set),
		.clr_i  ({4{ms_end}}),
		.hold_i (ms_hold),
		.flag_o (delta),
		.pend_o (delta_pend)
	);

	assign tx_all_empty = tx_hold_empty_q && tx_shift_idle_i;
	assign rx_line_irq  = irq_enable_reg_q[ucs_pkg::IE_RX_LINE] && (|line_flags[4:1]);

	// fixed priority, lowest last; loopback deltas still pass the enable
	always_comb begin
		if (rx_line_irq)
			irq_ident_reg = ucs_pkg::IRQ_ID_RX_LINE;
		else if (irq_enable_reg_q[ucs_pkg::IE_RX_DATA] && line_flags[ucs_pkg::LS_DATA_READY])
			irq_ident_reg = ucs_pkg::IRQ_ID_RX_DATA;
		else if (irq_enable_reg_q[ucs_pkg::IE_TX_HOLD] && tx_hold_empty_irq_q)
			irq_ident_reg = ucs_pkg::IRQ_ID_TX_HOLD;
		else if (irq_enable_reg_q[ucs_pkg::IE_MODEM] && (|delta))
			irq_ident_reg = ucs_pkg::IRQ_ID_MODEM;
		else
			irq_ident_reg = ucs_pkg::IRQ_ID_NONE;
	end
	assign irq_out_o = irq_ident_reg != ucs_pkg::IRQ_ID_NONE;

	always_comb begin
		modem_control_d  = modem_control_q;
		irq_enable_reg_d = irq_enable_reg_q;
		tx_hold_empty_d  = tx_hold_empty_q;
		tx_hold_empty_irq_d       = tx_hold_empty_irq_q;
		rdata_d          = rdata_q;
		rd_d             = rd_i;
		rb_rd_d          = rd_i && !dlab_i && addr_i == ucs_pkg::OFS_RX_BUFFER;
		raddr_d          = rd_i ? addr_i : raddr_q;
		if (mcr_wr)
			modem_control_d = wdata_i[4:0];
		if (ier_wr)
			irq_enable_reg_d = wdata_i[3:0];
		if (thr_wr)
			tx_hold_empty_d = 1'b0;
		if (tx_hold_to_shift_i)
			tx_hold_empty_d = 1'b1;
		if (thr_wr || (ii_end && rdata_q[3:0] == ucs_pkg::IRQ_ID_TX_HOLD))
			tx_hold_empty_irq_d = 1'b0;
		// enabling the source while already empty raises it as well
		if (tx_hold_to_shift_i || (ier_wr && wdata_i[ucs_pkg::IE_TX_HOLD]
				&& !irq_enable_reg_q[ucs_pkg::IE_TX_HOLD] && tx_hold_empty_q))
			tx_hold_empty_irq_d = 1'b1;
		if (rd_i) begin
			case (addr_i)
				ucs_pkg::OFS_RX_BUFFER:
					rdata_d = dlab_i ? 8'h00 : rx_data_i;
				ucs_pkg::OFS_IRQ_ENABLE:
					rdata_d = dlab_i ? 8'h00 : {4'h0, irq_enable_reg_q};
				ucs_pkg::OFS_IRQ_IDENT:
					rdata_d = {4'h0, irq_ident_reg};
				ucs_pkg::OFS_MODEM_CONTROL:
					rdata_d = {3'h0, modem_control_q};
				ucs_pkg::OFS_LINE_STATUS:
					rdata_d = {1'b0, tx_all_empty, tx_hold_empty_q, line_flags};
				ucs_pkg::OFS_MODEM_STATUS:
					rdata_d = {stat_q, delta};
				default:
					rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			modem_control_q  <= ucs_pkg::MODEM_CONTROL_RST;
			irq_enable_reg_q <= ucs_pkg::IRQ_ENABLE_RST;
			tx_hold_empty_q  <= ucs_pkg::TX_HOLD_EMPTY_RST;
			tx_hold_empty_irq_q       <= 1'b0;
			stat_q           <= '0;
			rdata_q          <= 8'h00;
			rd_q             <= 1'b0;
			rb_rd_q          <= 1'b0;
			raddr_q          <= 3'h0;
		end else begin
			modem_control_q  <= modem_control_d;
			irq_enable_reg_q <= irq_enable_reg_d;
			tx_hold_empty_q  <= tx_hold_empty_d;
			tx_hold_empty_irq_q       <= tx_hold_empty_irq_d;
			stat_q           <= stat_d;
			rdata_q          <= rdata_d;
			rd_q             <= rd_d;
			rb_rd_q          <= rb_rd_d;
			raddr_q          <= raddr_d;
		end
	end

	assign rdata_o           = rdata_q;
	assign serial_tx_pin_o   = loop ? 1'b1 : tx_shift_out_i;
	assign rx_serial_o       = loop ? tx_shift_out_i : serial_rx_pin_i;
	assign term_ready_n_o    = loop || !modem_control_q[ucs_pkg::MC_TERM_READY];
	assign req_send_n_o      = loop || !modem_control_q[ucs_pkg::MC_REQ_SEND];
	assign user_output_a_n_o = loop || !modem_control_q[ucs_pkg::MC_USER_A];
	assign user_output_b_n_o = loop || !modem_control_q[ucs_pkg::MC_USER_B];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_dr_set: assert property (rx_char_done_i && !ls_hold
		|=> line_flags[ucs_pkg::LS_DATA_READY])
		else $error("data ready not set after receive load");
	chk_dr_clear: assert property (rb_end && !rx_char_done_i
		|=> !line_flags[ucs_pkg::LS_DATA_READY])
		else $error("data ready not cleared by buffer read");
	chk_err_clear: assert property (ls_end && !rx_char_done_i && !(|line_pend)
		|=> line_flags[4:1] == 4'h0)
		else $error("error flags survive line status read");
	chk_err_hold: assert property (ls_hold && $past(ls_hold) |-> $stable(line_flags))
		else $error("line flag changed during status read");
	chk_pend_show: assert property (ls_end && line_pend[ucs_pkg::LS_PARITY]
		|=> line_flags[ucs_pkg::LS_PARITY])
		else $error("deferred parity flag lost at end of read");
	chk_lsr_msb: assert property (rd_i && addr_i == ucs_pkg::OFS_LINE_STATUS
		|=> !rdata_o[7])
		else $error("line status bit seven not zero");
	chk_mcr_upper: assert property (rd_i && addr_i == ucs_pkg::OFS_MODEM_CONTROL
		|=> rdata_o[7:5] == 3'h0)
		else $error("modem control upper bits not zero");
	chk_tx_hold_empty_write: assert property (thr_wr && !tx_hold_to_shift_i
		|=> !tx_hold_empty_q && !tx_all_empty)
		else $error("empty flags not cleared by holding write");
	chk_tx_hold_empty_set: assert property (tx_hold_to_shift_i |=> tx_hold_empty_q)
		else $error("holding empty not set on move to shifter");
	chk_tx_hold_empty_keep: assert property (!thr_wr && !tx_hold_to_shift_i
		|=> $stable(tx_hold_empty_q))
		else $error("holding empty changed without load or move");
	chk_tx_all_empty_busy: assert property (rd_i && addr_i == ucs_pkg::OFS_LINE_STATUS
		&& !tx_shift_idle_i |=> !rdata_o[ucs_pkg::LS_ALL_EMPTY])
		else $error("transmitter empty shown while shifter busy");
	chk_tx_hold_empty_ident: assert property (ii_end && !tx_hold_to_shift_i && !ier_wr
		&& rdata_q[3:0] == ucs_pkg::IRQ_ID_TX_HOLD |=> !tx_hold_empty_irq_q)
		else $error("holding empty interrupt not cleared by ident read");
	chk_dtr_drive: assert property (mcr_wr && wdata_i[0] && !wdata_i[4]
		|=> !term_ready_n_o)
		else $error("terminal ready pin not driven low");
	chk_loop_pins: assert property (loop |-> serial_tx_pin_o && term_ready_n_o
		&& req_send_n_o && user_output_a_n_o && user_output_b_n_o)
		else $error("loopback pins not at inactive level");
	chk_loop_rx: assert property (loop |-> rx_serial_o == tx_shift_out_i)
		else $error("receiver not fed from shifter in loopback");
	chk_line_path: assert property (!loop |-> rx_serial_o == serial_rx_pin_i
		&& serial_tx_pin_o == tx_shift_out_i)
		else $error("serial path wrong outside loopback");
	chk_delta_set: assert property (!ms_hold && delta_set[0] |=> delta[0])
		else $error("send delta not set on input change");
	chk_delta_clear: assert property (ms_end && !(|delta_set) && !(|delta_pend)
		|=> delta == 4'h0)
		else $error("deltas survive modem status read");
	chk_ms_read: assert property (rd_i && addr_i == ucs_pkg::OFS_MODEM_STATUS
		|=> rdata_o[3:0] == $past(delta))
		else $error("modem status read shows wrong deltas");
	chk_ring_edge: assert property (!ms_hold && !delta[2] && !delta_pend[2]
		&& !stat_q.ring && stat_now.ring |=> !delta[2])
		else $error("ring delta set on wrong edge");
	chk_line_prio: assert property (rx_line_irq |-> irq_out_o
		&& irq_ident_reg == ucs_pkg::IRQ_ID_RX_LINE)
		else $error("receive line interrupt not top priority");
	chk_modem_irq: assert property (irq_enable_reg_q[ucs_pkg::IE_MODEM] && (|delta)
		|-> irq_out_o)
		else $error("enabled modem change gives no interrupt");

	cov_overrun: cover property (line_set[ucs_pkg::LS_OVERRUN] ##1 ls_end);
	cov_loop_delta: cover property (loop && mcr_wr ##1 |delta);
	cov_tx_hold_empty_ident: cover property (irq_ident_reg == ucs_pkg::IRQ_ID_TX_HOLD ##[1:4] ii_end);
	cov_break_irq: cover property (rx_line_irq && line_flags[ucs_pkg::LS_BREAK]);
endmodule // ucs_line_modem

// file: test/ucs_modem_model.sv
// behavioural modem that drives the handshake inputs of the status block
`timescale 1ns/100ps
module ucs_modem_model #(
	parameter int LAG = 2
) (
	input  wire logic                clk_i,
	input  wire ucs_pkg::ucs_modem_t want_i,
	output logic                     clear_send_n_o,
	output logic                     set_ready_n_o,
	output logic                     ring_n_o,
	output logic                     carrier_n_o,
	output logic                     serial_rx_pin_o
);
	ucs_pkg::ucs_modem_t lag_q [LAG] = '{default: '0};

	// a real data set reacts late; the lag also keeps edges off the sampling edge
	always @(negedge clk_i) begin
		lag_q[0] <= want_i;
		for (int i = 1; i < LAG; i++) lag_q[i] <= lag_q[i-1];
	end

	assign clear_send_n_o  = ~lag_q[LAG-1].clear_send;
	assign set_ready_n_o   = ~lag_q[LAG-1].set_ready;
	assign ring_n_o        = ~lag_q[LAG-1].ring;
	assign carrier_n_o     = ~lag_q[LAG-1].carrier;
	// no characters are sent, so the line rests at mark
	assign serial_rx_pin_o = 1'b1;
endmodule // ucs_modem_model

// file: test/tb.sv
// self-checking bench for the line and modem status block
`timescale 1ns/100ps
module tb;
	localparam logic [2:0] A_RX = ucs_pkg::OFS_RX_BUFFER;
	localparam logic [2:0] A_IE = ucs_pkg::OFS_IRQ_ENABLE;
	localparam logic [2:0] A_ID = ucs_pkg::OFS_IRQ_IDENT;
	localparam logic [2:0] A_MC = ucs_pkg::OFS_MODEM_CONTROL;
	localparam logic [2:0] A_LS = ucs_pkg::OFS_LINE_STATUS;
	localparam logic [2:0] A_MS = ucs_pkg::OFS_MODEM_STATUS;
	logic                clk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic [2:0]          addr_i = 3'h0;
	logic                rd_i = 1'b0;
	logic                wr_i = 1'b0;
	logic [7:0]          wdata_i = 8'h00;
	logic                dlab_i = 1'b0;
	logic [7:0]          rx_data_i = 8'h00;
	logic                rx_char_done_i = 1'b0;
	logic                rx_parity_bad_i = 1'b0;
	logic                rx_stop_bad_i = 1'b0;
	logic                rx_break_i = 1'b0;
	logic                tx_hold_to_shift_i = 1'b0;
	logic                tx_shift_idle_i = 1'b1;
	logic                tx_shift_out_i = 1'b0;
	logic [7:0]          rdata_o, d;
	logic                tx_hold_load_o, serial_rx_pin_i, serial_tx_pin_o, rx_serial_o;
	logic                clear_send_n_i, set_ready_n_i, ring_n_i, carrier_n_i, irq_out_o;
	logic                term_ready_n_o, req_send_n_o, user_output_a_n_o, user_output_b_n_o;
	ucs_pkg::ucs_modem_t want = '0;
	int                  miscompares = 0;
	int                  num_checks = 0;
	int                  cycles = 0;
	wire  [7:0]          irq = {7'h0, irq_out_o};
	wire  [7:0]          pins = {4'h0, user_output_b_n_o, user_output_a_n_o, req_send_n_o,
		term_ready_n_o};

	ucs_line_modem dut_u (.clk_i, .rst_i, .addr_i, .rd_i, .wr_i, .wdata_i, .dlab_i, .rdata_o,
		.rx_data_i, .rx_char_done_i, .rx_parity_bad_i, .rx_stop_bad_i, .rx_break_i,
		.tx_hold_to_shift_i, .tx_shift_idle_i, .tx_shift_out_i, .tx_hold_load_o,
		.serial_rx_pin_i, .serial_tx_pin_o, .rx_serial_o, .clear_send_n_i, .set_ready_n_i,
		.ring_n_i, .carrier_n_i, .term_ready_n_o, .req_send_n_o, .user_output_a_n_o,
		.user_output_b_n_o, .irq_out_o);
	ucs_modem_model #(.LAG(2)) modem_u (.clk_i, .want_i(want), .clear_send_n_o(clear_send_n_i),
		.set_ready_n_o(set_ready_n_i), .ring_n_o(ring_n_i), .carrier_n_o(carrier_n_i),
		.serial_rx_pin_o(serial_rx_pin_i));

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// a generous ceiling: the whole sequence needs under two hundred cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rd(input logic [2:0] a);
		@(negedge clk_i);
		addr_i = a;
		rd_i = 1'b1;
		@(negedge clk_i);
		rd_i = 1'b0;
		d = rdata_o;
	endtask

	task automatic rdc(input logic [2:0] a, input string nm, input logic [7:0] m, e);
		rd(a);
		chk(nm, d & m, e);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(negedge clk_i);
		addr_i = a;
		wdata_i = v;
		wr_i = 1'b1;
		@(negedge clk_i);
		wr_i = 1'b0;
	endtask

	// bad = {break, stop, parity}
	task automatic rx_char(input logic [7:0] v, input logic [2:0] bad);
		@(negedge clk_i);
		rx_data_i = v;
		{rx_break_i, rx_stop_bad_i, rx_parity_bad_i} = bad;
		rx_char_done_i = 1'b1;
		@(negedge clk_i);
		rx_char_done_i = 1'b0;
		{rx_break_i, rx_stop_bad_i, rx_parity_bad_i} = 3'h0;
	endtask

	task automatic t_reset;
		rdc(A_LS, "line status", 8'hff, 8'h60);
		rdc(A_MC, "control", 8'hff, 8'h00);
		rdc(A_MS, "modem status", 8'hff, 8'h00);
		rdc(A_ID, "ident none", 8'h0f, 8'h01);
		rdc(3'h7, "unmapped", 8'hff, 8'h00);
		chk("pins idle", pins, 8'h0f);
		chk("irq idle", irq, 8'h00);
	endtask

	task automatic t_rx;
		rx_char(8'ha5, 3'h0);
		rdc(A_LS, "ready", 8'hff, 8'h61);
		rx_char(8'h5a, 3'h0);
		rdc(A_LS, "overrun", 8'hff, 8'h63);
		rdc(A_LS, "overrun read", 8'hff, 8'h61);
		dlab_i = 1'b1;
		rdc(A_RX, "divisor view", 8'hff, 8'h00);
		dlab_i = 1'b0;
		rdc(A_LS, "divisor kept", 8'h01, 8'h01);
		rdc(A_RX, "rx data", 8'hff, 8'h5a);
		rdc(A_LS, "ready read", 8'hff, 8'h60);
		wr(A_IE, 8'h01);
		rx_char(8'h44, 3'h0);
		chk("irq ready", irq, 8'h01);
		rdc(A_ID, "ident ready", 8'h0f, 8'h04);
		rdc(A_RX, "rx data 2", 8'hff, 8'h44);
		@(negedge clk_i);
		chk("irq ready off", irq, 8'h00);
		wr(A_IE, 8'h00);
	endtask

	task automatic t_err;
		wr(A_IE, 8'h04);
		for (int i = 0; i < 3; i++) begin
			rx_char(8'h10, 3'h1 << i);
			rx_char(8'h11, 3'h0);
			chk("irq line", irq, 8'h01);
			rdc(A_ID, "ident line", 8'h0f, 8'h06);
			rdc(A_LS, "errors", 8'h1f, 8'h03 | (8'h04 << i));
			rdc(A_RX, "rx data err", 8'hff, 8'h11);
			@(negedge clk_i);
			chk("irq line off", irq, 8'h00);
		end
		wr(A_IE, 8'h00);
		rx_char(8'h12, 3'h2);
		@(negedge clk_i);
		chk("irq masked", irq, 8'h00);
		rd(A_LS);
		rd(A_RX);
	endtask

	task automatic t_hold;
		@(negedge clk_i);
		addr_i = A_LS;
		rd_i = 1'b1;
		rx_char(8'h22, 3'h1);
		@(negedge clk_i);
		rd_i = 1'b0;
		chk("during read", rdata_o & 8'h1f, 8'h00);
		rdc(A_LS, "after read", 8'h1f, 8'h05);
		rd(A_RX);
	endtask

	task automatic t_tx;
		@(negedge clk_i);
		addr_i = A_RX;
		wdata_i = 8'h33;
		wr_i = 1'b1;
		#1 chk("hold load", {7'h0, tx_hold_load_o}, 8'h01);
		@(negedge clk_i);
		wr_i = 1'b0;
		tx_shift_idle_i = 1'b0;
		rdc(A_LS, "loaded", 8'h60, 8'h00);
		@(negedge clk_i);
		tx_hold_to_shift_i = 1'b1;
		@(negedge clk_i);
		tx_hold_to_shift_i = 1'b0;
		rdc(A_LS, "moved", 8'h60, 8'h20);
		rdc(A_LS, "moved again", 8'h60, 8'h20);
		tx_shift_idle_i = 1'b1;
		rdc(A_LS, "all empty", 8'h60, 8'h60);
		wr(A_IE, 8'h02);
		@(negedge clk_i);
		chk("irq hold", irq, 8'h01);
		rdc(A_ID, "ident hold", 8'h0f, 8'h02);
		@(negedge clk_i);
		chk("irq hold off", irq, 8'h00);
		wr(A_IE, 8'h00);
	endtask

	task automatic t_loop;
		wr(A_MC, 8'h0f);
		chk("pins on", pins, 8'h00);
		rdc(A_MC, "control rw", 8'hff, 8'h0f);
		wr(A_MC, 8'hff);
		rdc(A_MC, "control top", 8'hff, 8'h1f);
		chk("pins loop", pins, 8'h0f);
		chk("tx mark", {7'h0, serial_tx_pin_o}, 8'h01);
		#1 chk("rx fed", {7'h0, rx_serial_o}, 8'h00);
		wr(A_MC, 8'h12);
		want = '1;
		repeat (4) @(negedge clk_i);
		rdc(A_MS, "loop status", 8'hf0, 8'h10);
		wr(A_IE, 8'h08);
		rd(A_MS);
		wr(A_MC, 8'h11);
		repeat (3) @(negedge clk_i);
		chk("irq loop", irq, 8'h01);
		rdc(A_MS, "loop delta", 8'hff, 8'h23);
		want = '0;
		wr(A_IE, 8'h00);
		wr(A_MC, 8'h00);
		chk("tx follows", {7'h0, serial_tx_pin_o}, 8'h00);
		chk("rx from pin", {7'h0, rx_serial_o}, 8'h01);
		repeat (4) @(negedge clk_i);
		rd(A_MS);
	endtask

	task automatic t_modem;
		want.clear_send = 1'b1;
		repeat (4) @(negedge clk_i);
		rdc(A_MS, "send on", 8'hff, 8'h11);
		rdc(A_MS, "send read", 8'hff, 8'h10);
		want.ring = 1'b1;
		repeat (4) @(negedge clk_i);
		rdc(A_MS, "ring on", 8'hff, 8'h50);
		want.ring = 1'b0;
		repeat (4) @(negedge clk_i);
		rdc(A_MS, "ring off", 8'hff, 8'h14);
		wr(A_IE, 8'h08);
		want.carrier = 1'b1;
		repeat (4) @(negedge clk_i);
		chk("irq modem", irq, 8'h01);
		rdc(A_ID, "ident modem", 8'h0f, 8'h00);
		rdc(A_MS, "carrier on", 8'hff, 8'h98);
		@(negedge clk_i);
		chk("irq modem off", irq, 8'h00);
	endtask

	initial begin
		repeat (12) @(negedge clk_i);
		rst_i = 1'b0;
		t_reset();
		t_rx();
		t_err();
		t_hold();
		t_tx();
		t_loop();
		t_modem();
		report_and_stop();
	end
endmodule // tb
